// File: pea_map.svh
`ifndef PEA_MAP_SVH
`define PEA_MAP_SVH
// result widths
`define PEA_RAW_W 17
`define PEA_OUT_W 16
`define PEA_PWR_W 30
`define PEA_ACC_W 56
`define PEA_CNT_W 32
`define PEA_BUS_MSB_W 14
// eight-sample rolling average
`define PEA_AVG_DEPTH 8
`define PEA_AVG_SHIFT 3
// adaptive scaling at the slow rate
`define PEA_SLOW_SHIFT 7
`define PEA_SLOW_COUNT 32'h0000_0080
// fullness limit selections
`define PEA_LIM_15_16 2'h0
`define PEA_LIM_7_8 2'h1
`define PEA_LIM_3_4 2'h2
`define PEA_LIM_FULL 2'h3
// adaptive rate codes: shift that mimics 1024 samples per second
`define PEA_RATE_1024 2'h0
`define PEA_RATE_256 2'h1
`define PEA_RATE_64 2'h2
`define PEA_RATE_8 2'h3
`endif

// File: pea_pkg.sv
package pea_pkg;
   // one conversion from the front end
   typedef struct packed {
      logic [16:0] bus_raw;
      logic [16:0] sense_raw;
      logic [1:0] channel;
      logic bus_half;
      logic sense_half;
   } pea_conv_type;
   // readable snapshot of one channel
   typedef struct packed {
      logic [15:0] bus_voltage_result;
      logic [15:0] sense_voltage_result;
      logic [15:0] bus_avg;
      logic [15:0] sense_avg;
      logic [29:0] power_product;
      logic [55:0] energy_accum_value;
      logic [31:0] accum_count;
   } pea_snap_type;
   // host commands
   typedef enum logic [1:0] {
      PEA_CMD_NONE,
      PEA_CMD_REFRESH,
      PEA_CMD_KEEP,
      PEA_CMD_GENERAL
   } pea_cmd_type;
   typedef enum logic [1:0] {
      PEA_IDLE,
      PEA_MULT,
      PEA_ACCUM
   } pea_state_type;
endpackage : pea_pkg

// File: pea_accumulator.sv
`timescale 1ns/1ps
`include "pea_map.svh"
module pea_accumulator (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic conv_valid,
   input wire pea_pkg::pea_conv_type conv,
   input wire logic cycle_done,
   input wire pea_pkg::pea_cmd_type cmd,
   input wire logic low_rate_request,
   input wire logic adaptive_off,
   input wire logic [1:0] adaptive_rate,
   input wire logic pin_refresh_en,
   input wire logic bus_bipolar,
   input wire logic sense_bipolar,
   input wire logic [1:0] limit_sel,
   input wire logic [1:0] read_channel,
   output pea_pkg::pea_snap_type snap,
   output logic slow_rate,
   output logic [1:0] permute_pos,
   output logic avg_valid,
   output logic accum_full,
   output logic count_full
);
   // sign-preserving truncation of 17-bit raw to 16 readable bits
   function automatic logic [15:0] pea_export(input logic [16:0] v, input logic bip);
      pea_export = bip ? v[16:1] : v[15:0];
   endfunction : pea_export
   // fullness threshold compare for an unsigned magnitude
   function automatic logic pea_over(input logic [55:0] v, input logic [1:0] sel, input int w);
      logic [55:0] top;
      top = (56'h1 << w) - 56'h1;
      case (sel)
         `PEA_LIM_15_16: pea_over = v >= (top - (top >> 4));
         `PEA_LIM_7_8: pea_over = v >= (top - (top >> 3));
         `PEA_LIM_3_4: pea_over = v >= (top - (top >> 2));
         default: pea_over = v >= top;
      endcase
   endfunction : pea_over

   logic low_meta;
   logic low_sync;
   logic low_prev;
   logic [16:0] bus_hist [0:3][0:7];
   logic [16:0] sense_hist [0:3][0:7];
   logic [2:0] wr_ptr [0:3];
   logic [16:0] bus_last [0:3];
   logic [16:0] sense_last [0:3];
   logic signed [29:0] pwr_last [0:3];
   logic signed [55:0] accum [0:3];
   logic [31:0] count [0:3];
   logic [3:0] cycles_seen;
   logic [1:0] ch;
   logic signed [16:0] bus_s;
   logic signed [16:0] sense_s;
   pea_pkg::pea_state_type state;
   logic signed [29:0] prod;

   // two-flop synchroniser for the rate pin
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
      begin
         low_meta <= 1'b0;
         low_sync <= 1'b0;
         low_prev <= 1'b0;
      end
      else
      begin
         low_meta <= low_rate_request;
         low_sync <= low_meta;
         low_prev <= low_sync;
      end

   wire next_slow = low_sync;
   wire pin_edge = low_sync ^ low_prev;
   // pin refresh only when enabled, default off
   wire pin_refresh = pin_edge & pin_refresh_en;
   wire is_refresh = (cmd == pea_pkg::PEA_CMD_REFRESH) | (cmd == pea_pkg::PEA_CMD_GENERAL)
      | pin_refresh;
   wire is_snap = is_refresh | (cmd == pea_pkg::PEA_CMD_KEEP);

   // half range keeps precision by shifting the raw code up
   wire [16:0] bus_scaled = conv.bus_half ? {conv.bus_raw[16], conv.bus_raw[14:0], 1'b0}
      : conv.bus_raw;
   wire [16:0] sense_scaled = conv.sense_half
      ? {conv.sense_raw[16], conv.sense_raw[14:0], 1'b0} : conv.sense_raw;

   // shift amount: zero when adaptive is off, else slow pin wins, else programmed adaptive rate
   wire [2:0] rate_shift = adaptive_off ? 3'h0
      : slow_rate ? 3'(`PEA_SLOW_SHIFT)
      : (adaptive_rate == `PEA_RATE_256) ? 3'h2
      : (adaptive_rate == `PEA_RATE_64) ? 3'h4
      : (adaptive_rate == `PEA_RATE_8) ? 3'h7 : 3'h0;
   // one per sample when not scaling
   wire [31:0] count_step = 32'h1 << rate_shift;
   // sense 17 bits signed times 14 bus msbs
   wire signed [13:0] bus_msb = bus_s[16:3];
   wire signed [55:0] addend = 56'(prod) <<< rate_shift;
   wire signed [56:0] sum = {accum[ch][55], accum[ch]} + {addend[55], addend};
   // saturate on overflow in either direction
   wire sat_pos = !sum[56] & sum[55];
   wire sat_neg = sum[56] & !sum[55];
   wire signed [55:0] next_accum = sat_pos ? {1'b0, {55{1'b1}}}
      : sat_neg ? {1'b1, 55'h0} : sum[55:0];

   // conversion pipeline
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
      begin
         state <= pea_pkg::PEA_IDLE;
         ch <= 2'h0;
         bus_s <= 17'h0;
         sense_s <= 17'h0;
         prod <= 30'h0;
      end
      else
      begin
         case (state)
            pea_pkg::PEA_IDLE:
               if (conv_valid)
               begin
                  ch <= conv.channel;
                  bus_s <= bus_scaled;
                  sense_s <= sense_scaled;
                  state <= pea_pkg::PEA_MULT;
               end
            pea_pkg::PEA_MULT:
            begin
               prod <= 30'(sense_s * bus_msb);
               state <= pea_pkg::PEA_ACCUM;
            end
            default:
               state <= pea_pkg::PEA_IDLE;
         endcase
      end

   // per-channel history, accumulators and counters
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
      begin
         for (int c = 0; c < 4; c++)
         begin
            wr_ptr[c] <= 3'h0;
            bus_last[c] <= 17'h0;
            sense_last[c] <= 17'h0;
            pwr_last[c] <= 30'h0;
            accum[c] <= 56'h0;
            count[c] <= 32'h0;
            for (int i = 0; i < `PEA_AVG_DEPTH; i++)
            begin
               bus_hist[c][i] <= 17'h0;
               sense_hist[c][i] <= 17'h0;
            end
         end
      end
      else
      begin
         // refresh clears; accumulate loses this cycle's sample
         if (is_refresh)
            for (int c = 0; c < 4; c++)
            begin
               accum[c] <= 56'h0;
               count[c] <= 32'h0;
            end
         else if (state == pea_pkg::PEA_ACCUM)
         begin
            accum[ch] <= next_accum;
            count[ch] <= count[ch] + count_step;
         end
         if (state == pea_pkg::PEA_ACCUM)
         begin
            // store full 17-bit values in the ring
            bus_hist[ch][wr_ptr[ch]] <= bus_s;
            sense_hist[ch][wr_ptr[ch]] <= sense_s;
            wr_ptr[ch] <= wr_ptr[ch] + 3'h1;
            bus_last[ch] <= bus_s;
            sense_last[ch] <= sense_s;
            pwr_last[ch] <= prod;
         end
      end

   // rolling average of the selected channel, sign-extended sum
   logic signed [19:0] bus_sum;
   logic signed [19:0] sense_sum;
   always_comb
   begin
      bus_sum = 20'h0;
      sense_sum = 20'h0;
      for (int i = 0; i < `PEA_AVG_DEPTH; i++)
      begin
         bus_sum = bus_sum + 20'(signed'(bus_hist[read_channel][i]));
         sense_sum = sense_sum + 20'(signed'(sense_hist[read_channel][i]));
      end
   end
   wire [16:0] bus_avg = bus_sum[19:3];
   wire [16:0] sense_avg = sense_sum[19:3];
   wire [55:0] acc_mag = accum[read_channel][55] ? 56'(-accum[read_channel])
      : accum[read_channel];

   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
         snap <= '0;
      else if (is_snap)
      begin
         snap.bus_voltage_result <= pea_export(bus_last[read_channel], bus_bipolar);
         snap.sense_voltage_result <= pea_export(sense_last[read_channel], sense_bipolar);
         snap.bus_avg <= pea_export(bus_avg, bus_bipolar);
         snap.sense_avg <= pea_export(sense_avg, sense_bipolar);
         snap.power_product <= pwr_last[read_channel];
         snap.energy_accum_value <= accum[read_channel];
         snap.accum_count <= count[read_channel];
      end

   // average validity after eight cycles; permutation steps
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
      begin
         cycles_seen <= 4'h0;
         avg_valid <= 1'b0;
         permute_pos <= 2'h0;
         slow_rate <= 1'b0;
         accum_full <= 1'b0;
         count_full <= 1'b0;
      end
      else
      begin
         if (cycle_done)
         begin
            permute_pos <= permute_pos + 2'h1;
            if (cycles_seen != 4'h8)
               cycles_seen <= cycles_seen + 4'h1;
            // rate pin acts only from the next conversion cycle
            slow_rate <= next_slow;
         end
         avg_valid <= cycles_seen == 4'h8;
         accum_full <= pea_over(acc_mag, limit_sel, 55);
         count_full <= pea_over(56'(count[read_channel]), limit_sel, 32);
      end
endmodule : pea_accumulator

// File: pea_accumulator_asserts.sv
`timescale 1ns/1ps
module pea_accumulator_asserts (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic cycle_done,
   input wire pea_pkg::pea_cmd_type cmd,
   input wire logic pin_refresh_en,
   input wire logic low_rate_request,
   input wire pea_pkg::pea_snap_type snap,
   input wire logic slow_rate,
   input wire logic [1:0] permute_pos,
   input wire logic avg_valid
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   // snapshot moves only on a command while pin refresh is off
   a_snap_on_cmd: assert property (
      cmd == pea_pkg::PEA_CMD_NONE && !pin_refresh_en |=> $stable(snap))
      else $error("snapshot changed with no command");
   // permutation steps once per conversion cycle, wrapping after four
   a_perm_step: assert property (
      cycle_done |=> permute_pos == $past(permute_pos) + 2'h1)
      else $error("permute position did not step");
   a_perm_hold: assert property (!cycle_done |=> $stable(permute_pos))
      else $error("permute position moved mid cycle");
   // average validity rises only at a cycle end and never drops
   // the count reaches eight at the cycle end, the flag follows one edge later
   a_avg_rise: assert property ($rose(avg_valid) |-> $past(cycle_done, 2))
      else $error("average valid rose outside a cycle end");
   a_avg_stays: assert property (avg_valid |=> avg_valid)
      else $error("average valid dropped");
   // pin crosses two sync flops, so four samples are enough
   a_slow_hold: assert property (!cycle_done |=> $stable(slow_rate))
      else $error("slow rate changed mid cycle");
   a_slow_enter: assert property (low_rate_request[*4] ##0 cycle_done |=> slow_rate)
      else $error("slow rate not entered");
   a_slow_leave: assert property ((!low_rate_request)[*4] ##0 cycle_done |=> !slow_rate)
      else $error("slow rate not left");
endmodule : pea_accumulator_asserts
bind pea_accumulator pea_accumulator_asserts chk (.*);

// File: pea_host.sv
`timescale 1ns/1ps
module pea_host (
   input wire logic mclk,
   output pea_pkg::pea_cmd_type cmd
);
   // quiet until asked
   initial
      cmd = pea_pkg::PEA_CMD_NONE;
   // command stands one cycle, launched off the falling edge
   task automatic issue(input pea_pkg::pea_cmd_type c);
   begin
      @(negedge mclk);
      cmd = c;
      @(negedge mclk);
      cmd = pea_pkg::PEA_CMD_NONE;
   end
   endtask : issue
endmodule : pea_host

// File: pea_accumulator_bench.sv
`timescale 1ns/1ps
module pea_accumulator_bench;
   logic mclk, rst_b, conv_valid, cycle_done, adaptive_off, slow_rate, avg_valid, accum_full;
   logic count_full, bus_bipolar, sense_bipolar, low_rate_request, es_slow, av;
   logic pin_refresh_en = 1'b0;
   logic [1:0] adaptive_rate, limit_sel, read_channel, permute_pos;
   pea_pkg::pea_conv_type conv;
   pea_pkg::pea_cmd_type cmd;
   pea_pkg::pea_snap_type snap, es;
   int error_cnt, check_count, nd, sh[4] = '{0, 2, 4, 7};
   longint acc[4], lp[4];
   bit [31:0] cnt[4];
   bit [16:0] lb[4], ls[4], b0, s0;
   wire logic [5:0] flg = {slow_rate, permute_pos, avg_valid, accum_full, count_full};
   pea_accumulator DUT (.*);
   pea_host host (.*);
   // free-running core clock
   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // every comparison counted, mismatches reported at once
   task automatic check(input string n, input logic [255:0] seen, exp);
   begin
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   end
   endtask : check
   // cycle end, one conversion, then the model's view of it
   task automatic step(input bit [1:0] ch, input bit [16:0] b, s, input int k);
      longint p;
   begin
      @(negedge mclk);
      cycle_done = 1'b1;
      nd++;
      @(negedge mclk);
      cycle_done = 1'b0;
      conv_valid = 1'b1;
      conv = '{b, s, ch, 1'b0, 1'b0};
      @(negedge mclk);
      conv_valid = 1'b0;
      repeat (3) @(negedge mclk);
      // signed product, shifted add, saturating sum
      p = $signed(s) * $signed(b[16:3]);
      acc[ch] = acc[ch] + (p <<< k);
      if (acc[ch] > 64'sh7f_ffff_ffff_ffff)
         acc[ch] = 64'sh7f_ffff_ffff_ffff;
      else if (acc[ch] < -64'sh80_0000_0000_0000)
         acc[ch] = -64'sh80_0000_0000_0000;
      cnt[ch] = cnt[ch] + (32'h1 << k);
      lp[ch] = p;
      lb[ch] = b;
      ls[ch] = s;
   end
   endtask : step
   // snapshot command, then compare; averages only where known
   task automatic look(input pea_pkg::pea_cmd_type c);
      logic [255:0] m;
      int r;
   begin
      host.issue(c);
      @(negedge mclk);
      r = read_channel;
      es.bus_voltage_result = bus_bipolar ? lb[r][16:1] : lb[r][15:0];
      es.sense_voltage_result = sense_bipolar ? ls[r][16:1] : ls[r][15:0];
      es.bus_avg = es.bus_voltage_result;
      es.sense_avg = es.sense_voltage_result;
      es.power_product = lp[r][29:0];
      es.energy_accum_value = acc[r][55:0];
      es.accum_count = cnt[r];
      m = '1;
      if (!av)
         m[149:118] = 32'h0;
      check("snap", 256'(snap) & m, 256'(es) & m);
      check("flags", 256'(flg), 256'({es_slow, nd[1:0], nd > 7, 2'h0}));
      // refresh clears every channel after the snapshot
      if (c == pea_pkg::PEA_CMD_REFRESH || c == pea_pkg::PEA_CMD_GENERAL)
      begin
         acc = '{default: 0};
         cnt = '{default: 0};
      end
   end
   endtask : look
   // verdict and end of run
   task automatic print_verdict();
   begin
      if (error_cnt == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask : print_verdict
   // main sequence
   initial
   begin
      {rst_b, conv_valid, cycle_done, bus_bipolar, sense_bipolar, es_slow, av} = '0;
      {adaptive_rate, limit_sel, read_channel, low_rate_request} = '0;
      conv = '0;
      adaptive_off = 1'b1;
      void'($urandom(12));
      repeat (8) @(negedge mclk);
      rst_b = 1'b1;
      check("reset", 256'({snap, flg}), '0);
      b0 = 17'($urandom);
      s0 = 17'($urandom);
      // eight equal samples make the mean equal to the sample
      for (int i = 0; i < 8; i++)
      begin
         av = (i == 7);
         step(2'h0, b0, s0, 0);
         look(pea_pkg::PEA_CMD_KEEP);
      end
      // random samples break the equal-sample mean, so averages go unchecked
      av = 1'b0;
      // random channels and formats, refresh every fifth time
      for (int i = 0; i < 40; i++)
      begin
         {read_channel, limit_sel, bus_bipolar, sense_bipolar} = 6'($urandom);
         step(2'($urandom), 17'($urandom), 17'($urandom), 0);
         look(i % 5 == 4 ? pea_pkg::PEA_CMD_REFRESH : pea_pkg::PEA_CMD_KEEP);
      end
      look(pea_pkg::PEA_CMD_GENERAL);
      // each adaptive rate code scales data and count
      adaptive_off = 1'b0;
      for (int r = 0; r < 4; r++)
      begin
         adaptive_rate = 2'(r);
         step(read_channel, 17'($urandom), 17'($urandom), sh[r]);
         look(pea_pkg::PEA_CMD_KEEP);
      end
      // slow pin forces the seven-bit shift
      adaptive_rate = 2'h1;
      low_rate_request = 1'b1;
      repeat (4) @(negedge mclk);
      es_slow = 1'b1;
      step(read_channel, 17'($urandom), 17'($urandom), 7);
      look(pea_pkg::PEA_CMD_KEEP);
      low_rate_request = 1'b0;
      repeat (4) @(negedge mclk);
      es_slow = 1'b0;
      step(read_channel, 17'($urandom), 17'($urandom), sh[1]);
      look(pea_pkg::PEA_CMD_KEEP);
      print_verdict();
   end
endmodule : pea_accumulator_bench
